/* logic/qgb_consts.svh */
/*
 * Register indices, reset values and field positions of the quad bank
 * I/O block. Assumes it is included by the top module only.
 */
`ifndef QGB_CONSTS_SVH
`define QGB_CONSTS_SVH

// ********************************
// Register indices.
// ********************************
`define QGB_IX_ACT 8'h30
`define QGB_IX_D_DIR 8'hE0
`define QGB_IX_D_DAT 8'hE1
`define QGB_IX_D_POL 8'hE2
`define QGB_IX_A_DIR 8'hE3
`define QGB_IX_A_DAT 8'hE4
`define QGB_IX_A_POL 8'hE5
`define QGB_IX_A_EVT 8'hE6
`define QGB_IX_B_EVT 8'hE7
`define QGB_IX_C_EVT 8'hE8
`define QGB_IX_D_EVT 8'hE9
`define QGB_IX_B_DIR 8'hF0
`define QGB_IX_B_DAT 8'hF1
`define QGB_IX_B_POL 8'hF2
`define QGB_IX_C_DIR 8'hF4
`define QGB_IX_C_DAT 8'hF5
`define QGB_IX_C_POL 8'hF6
`define QGB_IX_IRQ_STAT 8'h40
`define QGB_IX_IRQ_MASK 8'h41

// ********************************
// Bus address fields.
// ********************************
`define QGB_ADDR_W 10
`define QGB_IX_MSB 9
`define QGB_IX_LSB 2

// ********************************
// Reset values.
// ********************************
`define QGB_RST_ACT 4'h0
`define QGB_RST_DIR 8'hFF
`define QGB_RST_DAT 8'h00
`define QGB_RST_POL 8'h00
`define QGB_RST_EVT 8'h00
`define QGB_RST_IRQ 4'h0

`endif

/* logic/qgb_pkg.sv */
/*
 * Types shared by the quad bank I/O block.
 * Assumes the constants header sits in the same folder.
 */
package qgb_pkg;

	// ********************************
	// Per bank configuration.
	// ********************************
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
		logic [7:0] pol;
	} qgb_bank_cfg_t;

	// ********************************
	// Bus request as seen by the decoder.
	// ********************************
	typedef struct packed {
		logic read;
		logic write;
		logic be0;
		logic [7:0] index;
		logic [7:0] wdata;
	} qgb_req_t;

	typedef enum logic {QGB_IDLE, QGB_ANSWER} qgb_bus_st_t;

endpackage : qgb_pkg

/* logic/qgb_top.sv */
/*
 * Four 8-bit I/O banks with direction, data, polarity and edge event
 * registers, an Avalon-MM register slave and one level interrupt.
 * Assumes a single 40 MHz clock; pin inputs may be asynchronous.
 */
`timescale 1ns/1ps
`include "qgb_consts.svh"

module qgb_top (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Avalon-MM slave.
	input wire logic [`QGB_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt.
	output logic irq,
	// Bank a pins.
	input wire logic [7:0] bank_a_pins_in,
	output logic [7:0] bank_a_pins_out,
	output logic [7:0] bank_a_pins_oe_n,
	// Bank b pins.
	input wire logic [7:0] bank_b_pins_in,
	output logic [7:0] bank_b_pins_out,
	output logic [7:0] bank_b_pins_oe_n,
	// Bank c pins.
	input wire logic [7:0] bank_c_pins_in,
	output logic [7:0] bank_c_pins_out,
	output logic [7:0] bank_c_pins_oe_n,
	// Bank d pins.
	input wire logic [7:0] bank_d_pins_in,
	output logic [7:0] bank_d_pins_out,
	output logic [7:0] bank_d_pins_oe_n
);

	// ********************************
	// Register index tables, bank a first.
	// ********************************
	localparam logic [3:0][7:0] DIR_IX = {
		`QGB_IX_D_DIR, `QGB_IX_C_DIR, `QGB_IX_B_DIR, `QGB_IX_A_DIR
	};
	localparam logic [3:0][7:0] DAT_IX = {
		`QGB_IX_D_DAT, `QGB_IX_C_DAT, `QGB_IX_B_DAT, `QGB_IX_A_DAT
	};
	localparam logic [3:0][7:0] POL_IX = {
		`QGB_IX_D_POL, `QGB_IX_C_POL, `QGB_IX_B_POL, `QGB_IX_A_POL
	};
	localparam logic [3:0][7:0] EVT_IX = {
		`QGB_IX_D_EVT, `QGB_IX_C_EVT, `QGB_IX_B_EVT, `QGB_IX_A_EVT
	};

	// ********************************
	// Declarations.
	// ********************************
	qgb_pkg::qgb_req_t req;
	qgb_pkg::qgb_bus_st_t bus_st_r;
	qgb_pkg::qgb_bank_cfg_t [3:0] cfg_r;
	logic [3:0] act_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;
	logic take;
	logic wr_take;
	logic rd_take;
	logic [3:0][7:0] pin_raw;
	logic [3:0][7:0] sync1_r;
	logic [3:0][7:0] sync2_r;
	logic [3:0][7:0] prev_r;
	logic [3:0][7:0] evt_r;
	logic [3:0][7:0] edge_det;
	logic [3:0][7:0] pin_out;
	logic [3:0][7:0] pin_oe_n;
	logic [3:0][7:0] rd_part;
	logic [3:0] bank_event;

	// ********************************
	// Bus request and handshake.
	// ********************************
	assign req.read = avs_read;
	assign req.write = avs_write;
	assign req.be0 = avs_byteenable[0];
	assign req.index = avs_address[`QGB_IX_MSB:`QGB_IX_LSB];
	assign req.wdata = avs_writedata[7:0];

	// Each request waits one cycle so read data can come from a flop.
	assign take = ce & (bus_st_r == qgb_pkg::QGB_ANSWER);
	assign wr_take = take & req.write & req.be0;
	assign rd_take = take & req.read;
	assign avs_waitrequest = (req.read | req.write) & (bus_st_r != qgb_pkg::QGB_ANSWER);
	assign avs_readdata = {24'h000000, rdata_r};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_st_r <= qgb_pkg::QGB_IDLE;
		end else if (ce) begin
			case (bus_st_r)
				qgb_pkg::QGB_IDLE: begin
					if (req.read | req.write) begin
						bus_st_r <= qgb_pkg::QGB_ANSWER;
					end
				end
				qgb_pkg::QGB_ANSWER: begin
					bus_st_r <= qgb_pkg::QGB_IDLE;
				end
				default: begin
					bus_st_r <= qgb_pkg::QGB_IDLE;
				end
			endcase
		end
	end

	// Read data is captured in the waiting cycle and held until the next read.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (ce && bus_st_r == qgb_pkg::QGB_IDLE && req.read) begin
			rdata_r <= rd_mux;
		end
	end

	// ********************************
	// Pin gathering.
	// ********************************
	assign pin_raw[0] = bank_a_pins_in;
	assign pin_raw[1] = bank_b_pins_in;
	assign pin_raw[2] = bank_c_pins_in;
	assign pin_raw[3] = bank_d_pins_in;
	assign bank_a_pins_out = pin_out[0];
	assign bank_b_pins_out = pin_out[1];
	assign bank_c_pins_out = pin_out[2];
	assign bank_d_pins_out = pin_out[3];
	assign bank_a_pins_oe_n = pin_oe_n[0];
	assign bank_b_pins_oe_n = pin_oe_n[1];
	assign bank_c_pins_oe_n = pin_oe_n[2];
	assign bank_d_pins_oe_n = pin_oe_n[3];

	// ********************************
	// Bank activation.
	// ********************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			act_r <= `QGB_RST_ACT;
		end else if (wr_take && req.index == `QGB_IX_ACT) begin
			act_r <= req.wdata[3:0];
		end
	end

	// ********************************
	// Per bank logic.
	// ********************************
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_bank
			logic [7:0] level;

			// Pins are asynchronous, so two flops come before any use.
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync1_r[g] <= 8'h00;
					sync2_r[g] <= 8'h00;
					prev_r[g] <= 8'h00;
				end else if (ce) begin
					sync1_r[g] <= pin_raw[g];
					sync2_r[g] <= sync1_r[g];
					prev_r[g] <= sync2_r[g];
				end
			end

			// Both edges count, and only on active input pins.
			assign edge_det[g] = (sync2_r[g] ^ prev_r[g]) & cfg_r[g].dir
				& {8{act_r[g]}};

			// An inactive bank floats its pins.
			assign pin_out[g] = cfg_r[g].data ^ cfg_r[g].pol;
			assign pin_oe_n[g] = cfg_r[g].dir | {8{~act_r[g]}};

			assign level = sync2_r[g] ^ cfg_r[g].pol;

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cfg_r[g].dir <= `QGB_RST_DIR;
				end else if (wr_take && req.index == DIR_IX[g]) begin
					cfg_r[g].dir <= req.wdata;
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cfg_r[g].pol <= `QGB_RST_POL;
				end else if (wr_take && req.index == POL_IX[g]) begin
					cfg_r[g].pol <= req.wdata;
				end
			end

			// Input bits keep their stored value whatever is written.
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cfg_r[g].data <= `QGB_RST_DAT;
				end else if (wr_take && req.index == DAT_IX[g]) begin
					cfg_r[g].data <= (req.wdata & ~cfg_r[g].dir)
						| (cfg_r[g].data & cfg_r[g].dir);
				end
			end

			// Only the bits handed out by the read are cleared, so a new
			// edge after the capture survives.
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					evt_r[g] <= `QGB_RST_EVT;
				end else if (ce) begin
					if (rd_take && req.index == EVT_IX[g]) begin
						evt_r[g] <= (evt_r[g] & ~rdata_r) | edge_det[g];
					end else begin
						evt_r[g] <= evt_r[g] | edge_det[g];
					end
				end
			end

			assign bank_event[g] = |edge_det[g];

			always_comb begin
				rd_part[g] = 8'h00;
				if (req.index == DIR_IX[g]) begin
					rd_part[g] = cfg_r[g].dir;
				end else if (req.index == DAT_IX[g]) begin
					rd_part[g] = (cfg_r[g].data & ~cfg_r[g].dir)
						| (level & cfg_r[g].dir);
				end else if (req.index == POL_IX[g]) begin
					rd_part[g] = cfg_r[g].pol;
				end else if (req.index == EVT_IX[g]) begin
					rd_part[g] = evt_r[g];
				end
			end
		end
	endgenerate

	// ********************************
	// Read multiplexer.
	// ********************************
	// Unmapped indices read as zero and ignore writes.
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < 4; i++) begin
			rd_mux = rd_mux | rd_part[i];
		end
		if (req.index == `QGB_IX_ACT) begin
			rd_mux = {4'h0, act_r};
		end else if (req.index == `QGB_IX_IRQ_STAT) begin
			rd_mux = {4'h0, irq_stat_r};
		end else if (req.index == `QGB_IX_IRQ_MASK) begin
			rd_mux = {4'h0, irq_mask_r};
		end
	end

	// ********************************
	// Interrupt status and mask.
	// ********************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask_r <= `QGB_RST_IRQ;
		end else if (wr_take && req.index == `QGB_IX_IRQ_MASK) begin
			irq_mask_r <= req.wdata[3:0];
		end
	end

	// A bank event in the clearing cycle is kept, as for the event bits.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= `QGB_RST_IRQ;
		end else if (ce) begin
			if (rd_take && req.index == `QGB_IX_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~rdata_r[3:0]) | bank_event;
			end else begin
				irq_stat_r <= irq_stat_r | bank_event;
			end
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

endmodule : qgb_top

/* verif/qgb_pins_model.sv */
/* Board side of one 8-pin bank: a level the bench sets, overridden by the block's drive.
   Assumes the block drives a pin only while its enable is low. */
`timescale 1ns/1ps
module qgb_pins_model (
	// Block side.
	input wire logic [7:0] pins_out,
	input wire logic [7:0] oe_n,
	// Board side.
	input wire logic [7:0] ext,
	output logic [7:0] pins_in
);
	// A driven pin reads back its own level, so outputs never look like board edges.
	assign pins_in = (pins_out & ~oe_n) | (ext & oe_n);
endmodule : qgb_pins_model

/* verif/qgb_top_asserts.sv */
/* Port checks of the quad bank I/O block.
   Assumes one clock, reset active high, bound to every block instance. */
`timescale 1ns/1ps
module qgb_top_asserts (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Register bus.
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Interrupt and pins.
	input wire logic irq,
	input wire logic [7:0] bank_a_pins_in,
	input wire logic [7:0] bank_a_pins_out,
	input wire logic [7:0] bank_a_pins_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic acc_w, acc_r, rd_evt;
	logic [7:0] pin_r;
	logic [2:0] calm_r;
	assign acc_w = avs_write && !avs_waitrequest;
	assign acc_r = avs_read && !avs_waitrequest;
	assign rd_evt = acc_r && avs_address[9:2] == 8'hE6 && calm_r == 3'h7;
	// Quiet time on the pins, so no edge can still sit in the synchroniser.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_r <= 8'h00;
			calm_r <= 3'h0;
		end else begin
			pin_r <= bank_a_pins_in;
			if (pin_r != bank_a_pins_in) begin
				calm_r <= 3'h0;
			end else if (calm_r != 3'h7) begin
				calm_r <= calm_r + 3'h1;
			end
		end
	end
	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_act_upper: assert property (
		acc_r && avs_address[9:2] == 8'h30 |-> avs_readdata[7:4] == 4'h0)
		else $error("reserved activation bits read nonzero");
	a_dir_reset: assert property (
		$fell(sys_rst) |-> bank_a_pins_oe_n == 8'hFF)
		else $error("pins driven after reset");
	a_out_reset: assert property (
		$fell(sys_rst) |-> bank_a_pins_out == 8'h00 && !irq)
		else $error("output level or irq not clear after reset");
	a_oe_by_write: assert property (
		!$stable(bank_a_pins_oe_n) |-> $past(acc_w))
		else $error("drive enable moved without a write");
	a_out_by_write: assert property (
		!$stable(bank_a_pins_out) |-> $past(acc_w))
		else $error("pin output moved without a write");
	a_irq_fall: assert property (
		$fell(irq) |-> $past(acc_r || acc_w))
		else $error("irq dropped without an access");
	a_evt_clear: assert property (
		rd_evt ##3 rd_evt |-> avs_readdata[7:0] == 8'h00)
		else $error("event status survived its read");
	c_evt_read: cover property (rd_evt && avs_readdata[7:0] != 8'h00);
	c_irq_up: cover property ($rose(irq));
	c_drive: cover property (bank_a_pins_oe_n == 8'h00);
endmodule : qgb_top_asserts

bind qgb_top qgb_top_asserts u_qgb_top_asserts (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.bank_a_pins_in(bank_a_pins_in), .bank_a_pins_out(bank_a_pins_out),
	.bank_a_pins_oe_n(bank_a_pins_oe_n));

/* verif/tb_qgb_top.sv */
/* Bench of the quad bank I/O block: bus tasks and register sequences.
   Assumes the design, pin model and checker are compiled first. */
`timescale 1ns/1ps
module tb_qgb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic [31:0] avs_writedata = 32'h00000000;
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest;
	wire logic irq;
	logic [3:0][7:0] ext = 32'h00000000;
	wire logic [3:0][7:0] pin_in;
	wire logic [3:0][7:0] pin_out;
	wire logic [3:0][7:0] oe_n;
	logic [7:0] ix [19] = '{8'h30, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
		8'hE8, 8'hE9, 8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF5, 8'hF6, 8'h40, 8'h41};
	logic [7:0] dx [4] = '{8'hE3, 8'hF0, 8'hF4, 8'hE0};
	int mismatches = 0;
	int check_count = 0;
	always #12.5 clk = ~clk;
	qgb_top u_qgb_top (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .bank_a_pins_in(pin_in[0]), .bank_a_pins_out(pin_out[0]),
		.bank_a_pins_oe_n(oe_n[0]), .bank_b_pins_in(pin_in[1]), .bank_b_pins_out(pin_out[1]),
		.bank_b_pins_oe_n(oe_n[1]), .bank_c_pins_in(pin_in[2]), .bank_c_pins_out(pin_out[2]),
		.bank_c_pins_oe_n(oe_n[2]), .bank_d_pins_in(pin_in[3]), .bank_d_pins_out(pin_out[3]),
		.bank_d_pins_oe_n(oe_n[3]));
	for (genvar i = 0; i < 4; i++) begin : g_pin
		qgb_pins_model u_qgb_pins_model (.pins_out(pin_out[i]), .oe_n(oe_n[i]), .ext(ext[i]),
			.pins_in(pin_in[i]));
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// The request stands until a rising edge samples waitrequest low; data is taken there.
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, wd};
		@(posedge clk);
		while (avs_waitrequest) begin
			@(posedge clk);
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		acc(1'b1, idx, wd, d);
	endtask : wr
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] got;
		acc(1'b0, idx, 8'h00, got);
		chk(got, exp);
	endtask : rc
	task automatic wrap_up;
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (ix[i]) begin
			rc(ix[i], ix[i] inside {8'hE0, 8'hE3, 8'hF0, 8'hF4} ? 8'hFF : 8'h00);
		end
		rc(8'h00, 8'h00);
		wr(8'hE6, 8'hFF);
		rc(8'hE6, 8'h00);
		wr(8'h30, 8'hFF);
		rc(8'h30, 8'h0F);
		wr(8'h41, 8'h01);
		wr(8'hE3, 8'hF0);
		wr(8'hE5, 8'h15);
		wr(8'hE4, 8'hA6);
		rc(8'hE4, 8'h16);
		@(negedge clk);
		chk(oe_n[0], 8'hF0);
		chk({4'h0, pin_out[0][3:0]}, 8'h03);
		@(posedge clk);
		ext[0] <= 8'h30;
		repeat (4) @(posedge clk);
		rc(8'hE4, 8'h26);
		chk({7'h00, irq}, 8'h01);
		rc(8'h40, 8'h01);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		rc(8'hE6, 8'h30);
		rc(8'hE6, 8'h00);
		// The edge lands on the edge that accepts the clearing read.
		@(posedge clk);
		ext[0] <= 8'hB0;
		rc(8'hE6, 8'h00);
		rc(8'hE6, 8'h80);
		ext[3:1] <= 24'h184281;
		repeat (4) @(posedge clk);
		rc(8'hE7, 8'h81);
		rc(8'hE8, 8'h42);
		rc(8'hE9, 8'h18);
		rc(8'h40, 8'h0F);
		foreach (dx[i]) begin
			wr(dx[i], 8'h00);
			wr(dx[i] + 8'h01, 8'h3C);
			wr(dx[i] + 8'h02, 8'hFF);
			rc(dx[i] + 8'h01, 8'h3C);
			chk(pin_out[i], 8'hC3);
			chk(oe_n[i], 8'h00);
		end
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rc(8'hE3, 8'hFF);
		rc(8'h30, 8'h00);
		wrap_up();
	end
endmodule : tb_qgb_top
